// ---- include/ampc_pkg.sv ----
// Constants shared by the audio converter mode/power control ends.
// Assumes a single 100 MHz system clock on both ends.
package ampc_pkg;
    // ==========
    // Clock and times
    // ==========
    localparam int CLK_MHZ = 100;          // System clock rate
    localparam int RAMP_MS = 25;           // Volume ramp and power down
    localparam int BOOT_MS = 20;           // Boot to active mode
    localparam int PWRUP_US = 100;         // Least supply/pin spacing at power up
    localparam int PWRDN_MS = 10;          // Least pin/supply spacing at power down
    localparam int CLK_LOSS_US = 10;       // Audio clock absence timeout
    localparam int RAMP_CYC = RAMP_MS * 1000 * CLK_MHZ;
    localparam int BOOT_CYC = BOOT_MS * 1000 * CLK_MHZ;
    localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
    localparam int PWRDN_CYC = PWRDN_MS * 1000 * CLK_MHZ;
    localparam int CLK_LOSS_CYC = CLK_LOSS_US * CLK_MHZ;
    localparam int BCLK_HALF_CYC = 4;      // Bit clock half period
    localparam int FRAME_BCLKS = 64;       // Bit clocks per frame
    // ==========
    // Enhancer and filter figures
    // ==========
    localparam logic signed [7:0] ENH_THRESH_DB = -8'sh24;  // Trigger level
    localparam logic [7:0] ENH_GAIN_MAX_DB = 8'h18;         // Gain ceiling
    localparam int ENH_MAX_RATE_KHZ = 48;                   // Highest rate allowed
    localparam logic [7:0] LL_LATENCY_TENTHS = 8'h4D;       // Low latency delay
    localparam logic [7:0] VOL_FULL = 8'hFF;                // Full volume
    // ==========
    // Controller register map
    // ==========
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_RATE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_RUN = 0;           // Request active mode
    localparam int CTRL_CLK = 1;           // Run audio clocks
    localparam int CTRL_ENH = 2;           // Request enhancer
    localparam int CTRL_MODE = 3;          // Mode (filter) select
    localparam int CTRL_MS = 4;            // High selects master
    localparam int CTRL_FORMAT_SELECT_LOW_PIN = 5;
    localparam int CTRL_FORMAT_SELECT_HIGH_PIN = 6;
    localparam int STAT_ON = 0;            // Shutdown pin released
    localparam int STAT_SETTLE = 1;        // Waiting before release
    localparam int STAT_OFF_OK = 2;        // Supplies may be removed
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [7:0] RATE_RST = 8'h30;  // Sample rate in kHz
endpackage : ampc_pkg

// ---- include/ampc_pins_if.sv ----
// Configuration, shutdown and audio clock pins between controller and converter.
// Assumes both ends share clk; all pins are one-way from the controller.
`timescale 1ns/10ps
interface ampc_pins_if;
    logic shutdown_n_pin;            // Low holds converter in shutdown
    logic enhancer_select_pin;       // Enhancer request
    logic mode_select_low_pin;       // High picks low latency filter
    logic master_slave_select_pin;   // Low picks slave
    logic format_select_low_pin;
    logic format_select_high_pin;
    logic bclk;                      // Bit clock
    logic fsync;                     // Frame sync
    // Controller end
    modport host (output shutdown_n_pin, enhancer_select_pin, mode_select_low_pin,
        master_slave_select_pin, format_select_low_pin, format_select_high_pin,
        bclk, fsync);
    // Converter end
    modport dev (input shutdown_n_pin, enhancer_select_pin, mode_select_low_pin,
        master_slave_select_pin, format_select_low_pin, format_select_high_pin,
        bclk, fsync);
endinterface : ampc_pins_if

// ---- design/ampc_device.sv ----
// Converter end: shutdown/boot sequencing, clock-driven channel power, enhancer.
// Assumes pins arrive asynchronously and are synchronised here.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
// Summary of operation
// - Enhancer only in slave with select high
// - Enhancer gains below -36 dB input
// - Enhancer gain never exceeds 24 dB
// - Controller avoids enhancer above 48 kHz
// - Shutdown low ramps volume, powers down 25ms
// - Shutdown high boots to active, 20 ms
// - Controller releases after supply, pins set
// - Clocks present power channels, start sending
// - Clocks stop power channels down
// - Slave, formats low give four-channel TDM
// - Clocks may start after pins set
// - Shutdown anytime; re-entry repeats sequence
// - Controller holds shutdown until supply settled
// - Power-up spacing at least 100 us
// - Power-down spacing at least 10 ms
// - Low latency filter delay 7.7 samples
module ampc_device import ampc_pkg::*; #(
    parameter int NCH = 4,                    // Converter channels
    parameter int P_RAMP_CYC = RAMP_CYC,      // Ramp-down length
    parameter int P_BOOT_CYC = BOOT_CYC,      // Boot length
    parameter int P_LOSS_CYC = CLK_LOSS_CYC   // Clock loss timeout
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    ampc_pins_if.dev pins,
    input wire logic signed [7:0] sample_level_db_i,
    output logic active_o,
    output logic shutdown_o,
    output logic analog_on_o,
    output logic [NCH-1:0] chan_power_o,
    output logic tx_enable_o,
    output logic [7:0] volume_o,
    output logic enhancer_on_o,
    output logic [7:0] enhancer_gain_db_o,
    output logic tdm4_slave_o,
    output logic master_o,
    output logic [1:0] format_o,
    output logic low_latency_o,
    output logic [7:0] latency_tenths_o
);
    // ==========
    // Pin synchronisers
    // ==========
    typedef enum logic [3:0] {
        ST_SHDN = 4'b0001,
        ST_BOOT = 4'b0010,
        ST_ACTIVE = 4'b0100,
        ST_RAMP = 4'b1000
    } ampc_dev_state_t;

    logic [7:0] raw;                    // Pins as they arrive
    logic [7:0] s1_ff, s2_ff, s3_ff;    // Three stage synchroniser
    logic [7:0] pin_ff, nxt_pin;        // Filtered pin levels
    logic bclk_prev_ff;                 // Previous filtered bit clock
    logic [23:0] loss_ff, nxt_loss;     // Cycles since last bit clock edge
    logic clk_ok_ff, nxt_clk_ok;        // Audio clocks present
    ampc_dev_state_t state_ff, nxt_state;
    logic [23:0] cnt_ff, nxt_cnt;       // Phase timer
    logic [23:0] step_ff, nxt_step;     // Volume step timer
    logic [7:0] vol_ff, nxt_vol;        // Record volume
    logic [4:0] cfg_ff, nxt_cfg;        // Captured configuration
    logic [7:0] gain_ff, nxt_gain;      // Enhancer gain
    logic signed [8:0] headroom;        // Threshold minus level
    logic enh_en;                       // Enhancer allowed

    localparam logic [23:0] STEP_CYC = 24'(P_RAMP_CYC / 256);

    assign raw = {pins.fsync, pins.bclk, pins.format_select_high_pin,
        pins.format_select_low_pin, pins.master_slave_select_pin,
        pins.mode_select_low_pin, pins.enhancer_select_pin, pins.shutdown_n_pin};

    // Level changes only once stages two and three agree
    always_comb begin
        nxt_pin = (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
    end

    // Synchroniser registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff <= 8'h00;
            s2_ff <= 8'h00;
            s3_ff <= 8'h00;
            pin_ff <= 8'h00;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // ==========
    // Audio clock presence
    // ==========
    always_comb begin
        nxt_loss = loss_ff;
        nxt_clk_ok = clk_ok_ff;
        if (pin_ff[6] != bclk_prev_ff) begin
            // Edge seen: clocks present
            nxt_loss = 24'h00_0000;
            nxt_clk_ok = 1'b1;
        end else if (loss_ff >= 24'(P_LOSS_CYC)) begin
            nxt_clk_ok = 1'b0;
        end else begin
            nxt_loss = loss_ff + 24'h00_0001;
        end
    end

    // Clock detector registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bclk_prev_ff <= 1'b0;
            loss_ff <= 24'h00_0000;
            clk_ok_ff <= 1'b0;
        end else begin
            bclk_prev_ff <= pin_ff[6];
            loss_ff <= nxt_loss;
            clk_ok_ff <= nxt_clk_ok;
        end
    end

    // ==========
    // Power sequencer
    // ==========
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 24'h00_0001;
        nxt_step = step_ff;
        nxt_vol = vol_ff;
        nxt_cfg = cfg_ff;
        case (state_ff)
            ST_SHDN: begin
                nxt_cnt = 24'h00_0000;
                if (pin_ff[0]) begin
                    nxt_cfg = pin_ff[5:1];
                    nxt_state = ST_BOOT;
                end
            end
            ST_BOOT: begin
                if (!pin_ff[0]) begin
                    nxt_state = ST_SHDN;
                end else if (cnt_ff >= 24'(P_BOOT_CYC - 1)) begin
                    nxt_vol = VOL_FULL;
                    nxt_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                nxt_cnt = 24'h00_0000;
                nxt_step = 24'h00_0000;
                if (!pin_ff[0]) begin
                    nxt_state = ST_RAMP;
                end
            end
            default: begin
                if (step_ff >= STEP_CYC - 24'h00_0001) begin
                    nxt_step = 24'h00_0000;
                    if (vol_ff != 8'h00) begin
                        nxt_vol = vol_ff - 8'h01;
                    end
                end else begin
                    nxt_step = step_ff + 24'h00_0001;
                end
                if (cnt_ff >= 24'(P_RAMP_CYC - 1)) begin
                    nxt_vol = 8'h00;
                    nxt_state = ST_SHDN;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_SHDN;
            cnt_ff <= 24'h00_0000;
            step_ff <= 24'h00_0000;
            vol_ff <= 8'h00;
            cfg_ff <= 5'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            step_ff <= nxt_step;
            vol_ff <= nxt_vol;
            cfg_ff <= nxt_cfg;
        end
    end

    // ==========
    // Enhancer gain
    // ==========
    // slave and select pin high
    assign enh_en = !cfg_ff[2] && cfg_ff[0];
    assign headroom = 9'(ENH_THRESH_DB) - 9'(sample_level_db_i);

    always_comb begin
        nxt_gain = 8'h00;
        if (enh_en && state_ff == ST_ACTIVE && headroom > 9'sh000) begin
            if (headroom > $signed({1'b0, ENH_GAIN_MAX_DB})) begin
                nxt_gain = ENH_GAIN_MAX_DB;
            end else begin
                nxt_gain = headroom[7:0];
            end
        end
    end

    // Gain register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_ff <= 8'h00;
        end else begin
            gain_ff <= nxt_gain;
        end
    end

    // ==========
    // Outputs
    // ==========
    assign active_o = state_ff == ST_ACTIVE;
    assign shutdown_o = state_ff == ST_SHDN;
    assign analog_on_o = state_ff != ST_SHDN;
    assign chan_power_o = {NCH{clk_ok_ff && (state_ff == ST_ACTIVE || state_ff == ST_RAMP)}};
    assign tx_enable_o = clk_ok_ff && (state_ff == ST_ACTIVE || state_ff == ST_RAMP);
    assign volume_o = vol_ff;
    assign enhancer_on_o = enh_en && state_ff == ST_ACTIVE;
    assign enhancer_gain_db_o = gain_ff;
    assign tdm4_slave_o = cfg_ff[4:2] == 3'h0;
    assign master_o = cfg_ff[2];
    assign format_o = cfg_ff[4:3];
    assign low_latency_o = cfg_ff[1];
    assign latency_tenths_o = cfg_ff[1] ? LL_LATENCY_TENTHS : 8'h00;
endmodule : ampc_device

// ---- design/ampc_host.sv ----
// Controller end: drives shutdown, configuration pins and audio clocks.
// Assumes software on Avalon-MM and a board supply-good input.
`timescale 1ns/10ps
module ampc_host import ampc_pkg::*; #(
    parameter int P_PWRUP_CYC = PWRUP_CYC,   // Wait before release
    parameter int P_PWRDN_CYC = PWRDN_CYC,   // Wait after shutdown
    parameter int P_HALF = BCLK_HALF_CYC,    // Bit clock half period
    parameter int P_FRAME = FRAME_BCLKS      // Bit clocks per frame
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic supply_ok_i,
    output logic supply_off_ok_o,
    ampc_pins_if.host pins
);
    // ==========
    // Declarations
    // ==========
    typedef enum logic [3:0] {
        H_OFF = 4'b0001,
        H_SETTLE = 4'b0010,
        H_ON = 4'b0100,
        H_DRAIN = 4'b1000
    } ampc_host_state_t;

    logic ack_ff, nxt_ack;              // One wait state per access
    logic [31:0] rd_ff, nxt_rd;         // Read data
    logic [6:0] ctrl_ff, nxt_ctrl;      // Control register
    logic [7:0] rate_ff, nxt_rate;      // Sample rate register
    ampc_host_state_t st_ff, nxt_st;
    logic [23:0] cnt_ff, nxt_cnt;       // Sequencing timer
    logic [5:0] pin_ff, nxt_pin;        // Shutdown and config pins
    logic [7:0] div_ff, nxt_div;        // Bit clock divider
    logic [7:0] bit_ff, nxt_bit;        // Bit position in frame
    logic bclk_ff, nxt_bclk;
    logic fs_ff, nxt_fs;
    logic take;                         // Access completes this edge

    // ==========
    // Avalon slave
    // ==========
    assign take = (avs_read_i || avs_write_i) && ack_ff;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;

    always_comb begin
        nxt_ack = (avs_read_i || avs_write_i) && !ack_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rate = rate_ff;
        nxt_rd = rd_ff;
        if (avs_read_i && !ack_ff) begin
            // Read data ready when waitrequest falls
            if (avs_address_i == REG_CTRL) begin
                nxt_rd = {25'h000_0000, ctrl_ff};
            end else if (avs_address_i == REG_RATE) begin
                nxt_rd = {24'h00_0000, rate_ff};
            end else if (avs_address_i == REG_STATUS) begin
                nxt_rd = {29'h0000_0000, st_ff == H_OFF, st_ff == H_SETTLE, st_ff == H_ON};
            end else begin
                nxt_rd = 32'h0000_0000;
            end
        end
        if (avs_write_i && take && avs_byteenable_i[0]) begin
            if (avs_address_i == REG_CTRL) begin
                nxt_ctrl = avs_writedata_i[6:0];
            end else if (avs_address_i == REG_RATE) begin
                nxt_rate = avs_writedata_i[7:0];
            end
        end
    end

    // Bus registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
            ctrl_ff <= CTRL_RST;
            rate_ff <= RATE_RST;
        end else begin
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
            ctrl_ff <= nxt_ctrl;
            rate_ff <= nxt_rate;
        end
    end

    // ==========
    // Shutdown sequencer
    // ==========
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + 24'h00_0001;
        nxt_pin = pin_ff;
        case (st_ff)
            H_OFF: begin
                nxt_cnt = 24'h00_0000;
                nxt_pin[0] = 1'b0;
                if (supply_ok_i && ctrl_ff[CTRL_RUN]) begin
                    nxt_pin[1] = ctrl_ff[CTRL_ENH] && (rate_ff <= 8'(ENH_MAX_RATE_KHZ));
                    nxt_pin[2] = ctrl_ff[CTRL_MODE];
                    nxt_pin[3] = ctrl_ff[CTRL_MS];
                    nxt_pin[4] = ctrl_ff[CTRL_FORMAT_SELECT_LOW_PIN];
                    nxt_pin[5] = ctrl_ff[CTRL_FORMAT_SELECT_HIGH_PIN];
                    nxt_st = H_SETTLE;
                end
            end
            H_SETTLE: begin
                if (!supply_ok_i || !ctrl_ff[CTRL_RUN]) begin
                    nxt_st = H_OFF;
                end else if (cnt_ff >= 24'(P_PWRUP_CYC - 1)) begin
                    nxt_pin[0] = 1'b1;
                    nxt_st = H_ON;
                end
            end
            H_ON: begin
                nxt_cnt = 24'h00_0000;
                if (!supply_ok_i || !ctrl_ff[CTRL_RUN]) begin
                    nxt_pin[0] = 1'b0;
                    nxt_st = H_DRAIN;
                end
            end
            default: begin
                // wait out power-down spacing before supply off
                if (cnt_ff >= 24'(P_PWRDN_CYC - 1)) begin
                    nxt_st = H_OFF;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= H_OFF;
            cnt_ff <= 24'h00_0000;
            pin_ff <= 6'h00;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            pin_ff <= nxt_pin;
        end
    end

    // ==========
    // Audio clock generator
    // ==========
    always_comb begin
        nxt_div = div_ff + 8'h01;
        nxt_bclk = bclk_ff;
        nxt_bit = bit_ff;
        nxt_fs = fs_ff;
        if (st_ff != H_ON || !ctrl_ff[CTRL_CLK]) begin
            nxt_div = 8'h00;
            nxt_bclk = 1'b0;
            nxt_bit = 8'h00;
            nxt_fs = 1'b0;
        end else if (div_ff >= 8'(P_HALF - 1)) begin
            nxt_div = 8'h00;
            nxt_bclk = !bclk_ff;
            // Frame sync changes on falling edge
            if (bclk_ff) begin
                nxt_bit = (bit_ff >= 8'(P_FRAME - 1)) ? 8'h00 : bit_ff + 8'h01;
                nxt_fs = nxt_bit == 8'h00;
            end
        end
    end

    // Clock generator registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff <= 8'h00;
            bclk_ff <= 1'b0;
            bit_ff <= 8'h00;
            fs_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            bclk_ff <= nxt_bclk;
            bit_ff <= nxt_bit;
            fs_ff <= nxt_fs;
        end
    end

    // ==========
    // Outputs
    // ==========
    assign avs_readdata_o = rd_ff;
    assign supply_off_ok_o = st_ff == H_OFF;
    assign pins.shutdown_n_pin = pin_ff[0];
    assign pins.enhancer_select_pin = pin_ff[1];
    assign pins.mode_select_low_pin = pin_ff[2];
    assign pins.master_slave_select_pin = pin_ff[3];
    assign pins.format_select_low_pin = pin_ff[4];
    assign pins.format_select_high_pin = pin_ff[5];
    assign pins.bclk = bclk_ff;
    assign pins.fsync = fs_ff;
endmodule : ampc_host

// ---- testbench/ampc_pins_sva.sv ----
// Checker for the pin link between controller and converter.
// Assumes one clock; placed beside the pins interface.
`timescale 1ns/10ps
module ampc_pins_sva #(
    parameter int P_PWRUP_CYC = 200,
    parameter int P_PWRDN_CYC = 200
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic shutdown_n_pin,
    input wire logic enhancer_select_pin,
    input wire logic mode_select_low_pin,
    input wire logic master_slave_select_pin,
    input wire logic format_select_low_pin,
    input wire logic format_select_high_pin,
    input wire logic bclk,
    input wire logic fsync
);
    // ==========
    // Helpers
    // ==========
    wire [4:0] cfg = {enhancer_select_pin, mode_select_low_pin,
        master_slave_select_pin, format_select_low_pin, format_select_high_pin};
    logic [15:0] lo_cnt_ff, nxt_lo_cnt; // Cycles held in shutdown
    logic on_ff, nxt_on; // Released once already
    // Low time counter
    always_comb begin
        nxt_lo_cnt = shutdown_n_pin ? 16'h0000 : lo_cnt_ff + 16'h0001;
        nxt_on = on_ff | shutdown_n_pin;
    end
    // Register helpers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_cnt_ff <= 16'h0000;
            on_ff <= 1'b0;
        end else begin
            lo_cnt_ff <= nxt_lo_cnt;
            on_ff <= nxt_on;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========
    // Assertions
    // ==========
    chk_cfg_hold_on: assert property (shutdown_n_pin |-> $stable(cfg))
        else $error("config pins moved while released");
    chk_cfg_pre_rel: assert property ($rose(shutdown_n_pin) |-> cfg == $past(cfg, 2))
        else $error("config pins not settled at release");
    chk_clk_off_shdn: assert property (!shutdown_n_pin [*2] |-> !bclk && !fsync)
        else $error("audio clocks run in shutdown");
    chk_rel_quiet: assert property ($rose(shutdown_n_pin) |-> !bclk && !fsync)
        else $error("audio clocks before release");
    chk_bclk_low: assert property ($rose(bclk) |-> !$past(bclk, 4))
        else $error("bit clock low phase short");
    chk_fsync_width: assert property ($rose(fsync) |-> ##8 !fsync)
        else $error("frame sync width wrong");
    chk_pwrup_space: assert property ($rose(shutdown_n_pin) |-> lo_cnt_ff >= P_PWRUP_CYC - 1)
        else $error("release too soon");
    chk_pwrdn_space: assert property ($rose(shutdown_n_pin) && on_ff |->
        lo_cnt_ff >= P_PWRUP_CYC + P_PWRDN_CYC - 1)
        else $error("shutdown too short");
    cov_release: cover property ($rose(shutdown_n_pin));
    cov_reenter: cover property ($fell(shutdown_n_pin) && on_ff);
    cov_frame: cover property ($rose(fsync));
endmodule : ampc_pins_sva

// ---- testbench/ampc_tb.sv ----
// Bench joining controller and converter over the pins interface.
// Assumes shortened counts; drives Avalon, supply and level inputs.
`timescale 1ns/10ps
module ampc_tb import ampc_pkg::*;;
    localparam int PB = 300, PR = 512, PL = 40, PU = 200, PD = 600;
    logic clk_i, rst_n_i, avs_read_i, avs_write_i, supply_ok_i;
    logic [3:0] avs_address_i, avs_byteenable_i, chan_power_o;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic avs_waitrequest_o, supply_off_ok_o, active_o, shutdown_o, analog_on_o;
    logic tx_enable_o, enhancer_on_o, tdm4_slave_o, master_o, low_latency_o;
    logic [7:0] volume_o, enhancer_gain_db_o, latency_tenths_o;
    logic [1:0] format_o;
    logic signed [7:0] sample_level_db_i;
    int fail_count = 0, n_tests = 0, seed;
    ampc_pins_if u_ampc_pins_if ();
    ampc_device #(.P_RAMP_CYC(PR), .P_BOOT_CYC(PB), .P_LOSS_CYC(PL)) u_ampc_device (
        .clk_i, .rst_n_i, .pins(u_ampc_pins_if), .sample_level_db_i, .active_o,
        .shutdown_o, .analog_on_o, .chan_power_o, .tx_enable_o, .volume_o,
        .enhancer_on_o, .enhancer_gain_db_o, .tdm4_slave_o, .master_o, .format_o,
        .low_latency_o, .latency_tenths_o);
    ampc_host #(.P_PWRUP_CYC(PU), .P_PWRDN_CYC(PD)) u_ampc_host (
        .clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .supply_ok_i,
        .supply_off_ok_o, .pins(u_ampc_pins_if));
    ampc_pins_sva #(.P_PWRUP_CYC(PU), .P_PWRDN_CYC(PD)) u_ampc_pins_sva (
        .clk_i, .rst_n_i, .shutdown_n_pin(u_ampc_pins_if.shutdown_n_pin),
        .enhancer_select_pin(u_ampc_pins_if.enhancer_select_pin),
        .mode_select_low_pin(u_ampc_pins_if.mode_select_low_pin),
        .master_slave_select_pin(u_ampc_pins_if.master_slave_select_pin),
        .format_select_low_pin(u_ampc_pins_if.format_select_low_pin),
        .format_select_high_pin(u_ampc_pins_if.format_select_high_pin),
        .bclk(u_ampc_pins_if.bclk), .fsync(u_ampc_pins_if.fsync));
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    // ==========
    // Tasks
    // ==========
    task end_sim;
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t bus %h exp %h", $time, got, exp);
        end
    endtask : cmp_bus
    task cmp_dev(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t out %h exp %h", $time, got, exp);
        end
    endtask : cmp_dev
    // One Avalon cycle, held until waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (i == 20) begin
            fail_count++;
            end_sim();
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    function automatic logic probe(input int k);
        case (k)
            0: return active_o;
            1: return (&chan_power_o) & tx_enable_o;
            2: return (|chan_power_o) | tx_enable_o;
            3: return u_ampc_pins_if.shutdown_n_pin;
            4: return shutdown_o;
            default: return supply_off_ok_o;
        endcase
    endfunction : probe
    // Bounded wait for a probe to reach a level
    task wt(input int k, input logic v, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk_i);
            if (probe(k) === v) break;
        end
        if (n == lim) begin
            fail_count++;
            end_sim();
        end
    endtask : wt
    // ==========
    // Main sequence
    // ==========
    initial begin
        logic [31:0] q;
        logic [6:0] cfg;
        logic signed [7:0] v;
        logic e;
        int n, it, j, rate, g;
        {clk_i, rst_n_i, avs_read_i, avs_write_i, supply_ok_i} = 5'h00;
        {avs_address_i, avs_writedata_i, sample_level_db_i} = '0;
        avs_byteenable_i = 4'hF;
        seed = 58;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(0, REG_RATE, 0, q);
        cmp_bus(q, {24'h00_0000, RATE_RST});
        bus(0, REG_STATUS, 0, q);
        cmp_bus(q, 32'h0000_0004);
        bus(0, 4'hC, 0, q);
        cmp_bus(q, 0);
        bus(1, REG_CTRL, 1, q);
        repeat (50) @(posedge clk_i);
        cmp_dev(u_ampc_pins_if.shutdown_n_pin, 0);
        bus(1, REG_CTRL, 0, q);
        supply_ok_i <= 1'b1;
        for (it = 0; it < 5; it++) begin
            cfg = $random(seed);
            cfg[1:0] = 2'b11;
            if (it == 0 || it >= 3) cfg = 7'h07;
            if (it == 1) cfg = 7'h1F;
            rate = (it % 2) ? 96 : 48;
            e = !cfg[4] && cfg[2] && rate <= 48;
            bus(1, REG_RATE, rate, q);
            bus(1, REG_CTRL, cfg, q);
            bus(0, REG_CTRL, 0, q);
            cmp_bus(q, cfg);
            wt(3, 1, PU + 50, n);
            wt(0, 1, PB + 20, n);
            cmp_dev(n >= PB && n <= PB + 10, 1);
            cmp_dev(volume_o, VOL_FULL);
            cmp_dev({master_o, format_o, low_latency_o}, {cfg[4], cfg[6:5], cfg[3]});
            cmp_dev(tdm4_slave_o, cfg[6:4] == 3'b000);
            cmp_dev(latency_tenths_o, cfg[3] ? LL_LATENCY_TENTHS : 8'h00);
            cmp_dev(enhancer_on_o, e);
            wt(1, 1, 200, n);
            cmp_dev(chan_power_o, 4'hF);
            for (j = 0; j < 4; j++) begin
                v = (j == 0) ? -8'sd37 : (j == 1) ? -8'sd36 : (j == 2) ? -8'sd90 : $random(seed);
                sample_level_db_i <= v;
                repeat (3) @(posedge clk_i);
                g = (e && v < -36) ? ((-36 - v > 24) ? 24 : -36 - v) : 0;
                cmp_dev(enhancer_gain_db_o, g);
            end
            bus(1, REG_CTRL, cfg ^ 7'h7C, q);
            repeat (10) @(posedge clk_i);
            cmp_dev({master_o, format_o, low_latency_o}, {cfg[4], cfg[6:5], cfg[3]});
            bus(1, REG_CTRL, cfg & 7'h7D, q);
            wt(2, 0, PL + 50, n);
            cmp_dev(chan_power_o, 0);
            bus(1, REG_CTRL, 0, q);
            wt(3, 0, 20, n);
            repeat (PR / 2) @(posedge clk_i);
            cmp_dev(volume_o > 0 && volume_o < VOL_FULL, 1);
            wt(4, 1, PR, n);
            cmp_dev(n + PR / 2 >= PR && n + PR / 2 <= PR + 10, 1);
            cmp_dev(analog_on_o, 0);
            cmp_dev(volume_o, 0);
            wt(5, 1, PD, n);
        end
        end_sim();
    end
endmodule : ampc_tb
